// File: logic/pgd_map.svh
`ifndef PGD_MAP_SVH
`define PGD_MAP_SVH
// host io ports
`define PGD_PORT_INDEX    16'h03ce
`define PGD_PORT_DATA     16'h03cf
// indexed register numbers
`define PGD_IDX_FILL      4'h0
`define PGD_IDX_FILL_EN   4'h1
`define PGD_IDX_MATCH     4'h2
`define PGD_IDX_LOGIC     4'h3
`define PGD_IDX_RDPLANE   4'h4
`define PGD_IDX_MODE      4'h5
`define PGD_IDX_MISC      4'h6
`define PGD_IDX_IGNORE    4'h7
`define PGD_IDX_MASK      4'h8
// field positions
`define PGD_ROT_LSB       0
`define PGD_LOP_LSB       3
`define PGD_WT_LSB        0
`define PGD_RT_BIT        3
`define PGD_PAIR_BIT      4
`define PGD_SHF_LSB       5
`define PGD_GSEL_BIT      0
`define PGD_CHAIN_BIT     1
`define PGD_WIN_LSB       2
// reset values (documented as undefined, cleared here)
`define PGD_RST_BYTE      8'h00
`endif

// File: logic/pgd_pkg.sv
`default_nettype none
package pgd_pkg;
  typedef enum logic [1:0] {WT_MODE0, WT_MODE1, WT_MODE2, WT_MODE3} pgd_wmode_type;
  typedef enum logic [1:0] {LOP_PASS, LOP_AND, LOP_OR, LOP_XOR} pgd_lop_type;
  typedef enum logic [1:0] {WIN_128K_A, WIN_128K_A2, WIN_32K_B0, WIN_32K_B8} pgd_win_type;
  typedef enum logic {ST_IDLE, ST_READ_DONE} pgd_state_type;
  // host io cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pgd_io_type;
  // host display memory cycle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  addr_lo;
    logic        chain4;
    logic [3:0]  plane_we;
    logic [7:0]  wdata;
  } pgd_mem_type;
  // all module state
  typedef struct packed {
    logic [3:0]    index;
    logic [3:0]    fill;
    logic [3:0]    fill_en;
    logic [3:0]    match;
    logic [7:0]    logic_rot;
    logic [1:0]    rd_plane;
    logic [6:0]    mode;
    logic [3:0]    misc;
    logic [3:0]    ignore;
    logic [7:0]    mask;
    logic [31:0]   latch;
    logic [7:0]    io_rdata;
    logic [7:0]    mem_rdata;
    logic [31:0]   wr_data;
    logic [3:0]    wr_en;
    logic          wr_stb;
    pgd_state_type state;
  } pgd_state_s_type;
endpackage
`default_nettype wire

// File: logic/pgd_datapath.sv
// How it works
// - index port low four bits choose which register the data port reaches
// - fill value gives one bit per plane replacing host data in mode 0
// - fill enable selects substitution in mode 0, ignored in mode 3
// - read mode 1 returns eight match bits comparing pixel colours to match value
// - ignore-planes bits drop planes from the colour comparison
// - logic op 00 pass, 01 and, 10 or, 11 xor with latches
// - rotate host data right by count before logic operation, except in mode 2, which takes host bits unrotated
// - read plane select picks returned plane byte; every read loads all four latches
// - shift format 1x 256-colour, 01 packed pixel, 00 normal planes
// - packed streams interleave even or odd bits of plane pairs
// - pairing and chaining bits stored and read back only
// - read type bit picks plane byte or compare result
// - write type field encodes modes 0 to 3 directly
// - mode 0 writes rotated data or fill, then logic op and mask
// - mode 1 writes latches unchanged; host loads latches first by reading
// - mode 2 uses host bits 3-0 as colour under bit mask
// - mode 3 writes fill bits, rotated data and mask form the mask
// - window field decodes 128K at A0000h, 32K at B0000h or B8000h
// - graphics select bit mirrors attribute mode control bit
// - bit mask keeps latch bits where zero, all planes, all writes
// - unused upper register bits read as zero
// - registers change only by host writes, never by drawing
// - chained reads use host address bits instead of plane select
`timescale 1ns/1ns
`default_nettype none
`include "pgd_map.svh"
module pgd_datapath (
  input  wire logic           i_ref_clk,
  input  wire logic           i_nrst,
  input  wire pgd_pkg::pgd_io_type  i_io,
  input  wire pgd_pkg::pgd_mem_type i_mem,
  input  wire logic [31:0]    i_plane_rdata,
  output logic [7:0]          o_io_rdata,
  output logic [7:0]          o_mem_rdata,
  output logic [31:0]         o_plane_wdata,
  output logic [3:0]          o_plane_we,
  output logic                o_plane_wr,
  output logic                o_mem_rvalid,
  output logic [19:0]         o_win_base,
  output logic [19:0]         o_win_limit,
  output logic                o_graphics_select,
  output logic [1:0]          o_shift_format,
  output logic [31:0]         o_packed_pixel_streams
);
  import pgd_pkg::*;

  pgd_state_s_type state_reg;
  pgd_state_s_type state_next;

  // rotate a byte right by n
  function automatic logic [7:0] rot_right(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] dd;
    dd = {d, d} >> n;
    return dd[7:0];
  endfunction

  // read-back value of an indexed register, unused bits zero
  function automatic logic [7:0] reg_read(input pgd_state_s_type s, input logic [3:0] idx);
    logic [7:0] r;
    r = 8'h00;
    case (idx)
      `PGD_IDX_FILL:    r = {4'h0, s.fill};
      `PGD_IDX_FILL_EN: r = {4'h0, s.fill_en};
      `PGD_IDX_MATCH:   r = {4'h0, s.match};
      `PGD_IDX_LOGIC:   r = {3'h0, s.logic_rot[4:0]};
      `PGD_IDX_RDPLANE: r = {6'h00, s.rd_plane};
      `PGD_IDX_MODE:    r = {1'b0, s.mode[6:3], 1'b0, s.mode[1:0]};
      `PGD_IDX_MISC:    r = {4'h0, s.misc};
      `PGD_IDX_IGNORE:  r = {4'h0, s.ignore};
      `PGD_IDX_MASK:    r = s.mask;
      default:          r = 8'h00;
    endcase
    return r;
  endfunction

  logic [2:0]    rot_cnt;
  pgd_lop_type   lop;
  pgd_wmode_type wmode;
  logic [7:0]    host_rot;
  logic [7:0]    cmp_res;
  logic [7:0]    pl_byte [4];
  logic [7:0]    lt_byte [4];
  logic [7:0]    sel_byte [4];
  logic [7:0]    alu_byte [4];
  logic [7:0]    eff_mask;
  logic [1:0]    rd_sel;

  assign rot_cnt  = state_reg.logic_rot[`PGD_ROT_LSB +: 3];
  assign lop      = pgd_lop_type'(state_reg.logic_rot[`PGD_LOP_LSB +: 2]);
  assign wmode    = pgd_wmode_type'(state_reg.mode[`PGD_WT_LSB +: 2]);
  assign host_rot = rot_right(i_mem.wdata, rot_cnt);
  // mode 3 derives its mask from rotated host data
  assign eff_mask = (wmode == WT_MODE3) ? (host_rot & state_reg.mask) : state_reg.mask;
  // chained reads use host address, else plane select
  assign rd_sel   = i_mem.chain4 ? i_mem.addr_lo : state_reg.rd_plane;

  // per plane write data path
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_plane
      assign pl_byte[p] = i_plane_rdata[8*p +: 8];
      assign lt_byte[p] = state_reg.latch[8*p +: 8];
      always_comb begin
        // source byte before logic op
        case (wmode)
          WT_MODE0: sel_byte[p] = (state_reg.fill_en[p]) ? {8{state_reg.fill[p]}} : host_rot;
          WT_MODE2: sel_byte[p] = {8{i_mem.wdata[p]}};
          WT_MODE3: sel_byte[p] = {8{state_reg.fill[p]}};
          default:  sel_byte[p] = lt_byte[p];
        endcase
        // logic operation with latch
        case (lop)
          LOP_AND: alu_byte[p] = sel_byte[p] & lt_byte[p];
          LOP_OR:  alu_byte[p] = sel_byte[p] | lt_byte[p];
          LOP_XOR: alu_byte[p] = sel_byte[p] ^ lt_byte[p];
          default: alu_byte[p] = sel_byte[p];
        endcase
      end
    end
  endgenerate

  // colour compare over the eight pixels of the addressed byte
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_cmp
      assign cmp_res[b] = &(~({pl_byte[3][b], pl_byte[2][b], pl_byte[1][b], pl_byte[0][b]}
                              ^ state_reg.match) | state_reg.ignore);
    end
  endgenerate

  // next state
  always_comb begin
    logic [31:0] wd;
    logic [3:0]  ix;
    wd = 32'h0;
    ix = state_reg.index;
    state_next = state_reg;
    state_next.wr_stb = 1'b0;
    state_next.state  = ST_IDLE;
    // host io writes are the only register updates
    if (i_io.wr && i_io.addr == `PGD_PORT_INDEX) begin
      state_next.index = i_io.wdata[3:0];
    end else if (i_io.wr && i_io.addr == `PGD_PORT_DATA) begin
      case (ix)
        `PGD_IDX_FILL:    state_next.fill      = i_io.wdata[3:0];
        `PGD_IDX_FILL_EN: state_next.fill_en   = i_io.wdata[3:0];
        `PGD_IDX_MATCH:   state_next.match     = i_io.wdata[3:0];
        `PGD_IDX_LOGIC:   state_next.logic_rot = {3'h0, i_io.wdata[4:0]};
        `PGD_IDX_RDPLANE: state_next.rd_plane  = i_io.wdata[1:0];
        `PGD_IDX_MODE:    state_next.mode      = i_io.wdata[6:0];
        `PGD_IDX_MISC:    state_next.misc      = i_io.wdata[3:0];
        `PGD_IDX_IGNORE:  state_next.ignore    = i_io.wdata[3:0];
        `PGD_IDX_MASK:    state_next.mask      = i_io.wdata;
        default:          state_next.index     = state_reg.index;
      endcase
    end
    // io read data
    if (i_io.rd && i_io.addr == `PGD_PORT_INDEX) begin
      state_next.io_rdata = {4'h0, state_reg.index};
    end else if (i_io.rd && i_io.addr == `PGD_PORT_DATA) begin
      state_next.io_rdata = reg_read(state_reg, ix);
    end
    // memory read: latch all planes, return plane byte or compare
    if (i_mem.rd) begin
      state_next.latch = i_plane_rdata;
      state_next.state = ST_READ_DONE;
      state_next.mem_rdata = state_reg.mode[`PGD_RT_BIT] ? cmp_res : pl_byte[rd_sel];
    end else if (i_mem.wr) begin
      // mask merges new data with latches; mode 1 writes the latches as they are
      for (int k = 0; k < 4; k++) begin
        if (wmode == WT_MODE1) begin
          wd[8*k +: 8] = lt_byte[k];
        end else begin
          wd[8*k +: 8] = (alu_byte[k] & eff_mask) | (lt_byte[k] & ~eff_mask);
        end
      end
      state_next.wr_data = wd;
      state_next.wr_en   = i_mem.plane_we;
      state_next.wr_stb  = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // memory window decode
  always_comb begin
    case (pgd_win_type'(state_reg.misc[`PGD_WIN_LSB +: 2]))
      WIN_32K_B0: begin
        o_win_base  = 20'hb0000;
        o_win_limit = 20'hb7fff;
      end
      WIN_32K_B8: begin
        o_win_base  = 20'hb8000;
        o_win_limit = 20'hbffff;
      end
      default: begin
        o_win_base  = 20'ha0000;
        o_win_limit = 20'hbffff;
      end
    endcase
  end

  // serializer load formats
  always_comb begin
    o_shift_format = state_reg.mode[`PGD_SHF_LSB +: 2];
    if (o_shift_format == 2'b01) begin
      for (int s = 0; s < 4; s++) begin
        for (int j = 0; j < 4; j++) begin
          // hi plane bits first, then lo plane
          o_packed_pixel_streams[8*s + j]     =
            state_reg.latch[8*((s/2)*2+1) + 2*j + (s%2)];
          o_packed_pixel_streams[8*s + 4 + j] =
            state_reg.latch[8*((s/2)*2) + 2*j + (s%2)];
        end
      end
    end else begin
      o_packed_pixel_streams = state_reg.latch;
    end
  end

  assign o_io_rdata        = state_reg.io_rdata;
  assign o_mem_rdata       = state_reg.mem_rdata;
  assign o_mem_rvalid      = (state_reg.state == ST_READ_DONE);
  assign o_plane_wdata     = state_reg.wr_data;
  assign o_plane_we        = state_reg.wr_stb ? state_reg.wr_en : 4'h0;
  assign o_plane_wr        = state_reg.wr_stb;
  assign o_graphics_select = state_reg.misc[`PGD_GSEL_BIT];
endmodule
`default_nettype wire

// File: testbench/pgd_props.sv
`timescale 1ns/1ns
`default_nettype none
module pgd_props
  import pgd_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire pgd_io_type  i_io,
  input wire pgd_mem_type i_mem,
  input wire logic [7:0]  o_io_rdata,
  input wire logic [7:0]  o_mem_rdata,
  input wire logic        o_mem_rvalid,
  input wire logic [3:0]  o_plane_we,
  input wire logic        o_plane_wr,
  input wire logic        o_graphics_select,
  input wire logic [19:0] o_win_base
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // accepted memory cycles, a read wins over a write
  sequence rd_s; i_mem.rd; endsequence
  sequence wr_s; i_mem.wr && !i_mem.rd; endsequence
  read_answer_a: assert property (rd_s |=> o_mem_rvalid)
    else $error("memory read not answered");
  read_quiet_a: assert property (!i_mem.rd |=> !o_mem_rvalid && $stable(o_mem_rdata))
    else $error("memory read data moved without a read");
  write_pulse_a: assert property (wr_s |=> o_plane_wr)
    else $error("memory write not issued");
  write_refused_a: assert property (!(i_mem.wr && !i_mem.rd) |=> !o_plane_wr)
    else $error("memory write without a request");
  plane_gate_a: assert property (wr_s |=> o_plane_we == $past(i_mem.plane_we))
    else $error("plane enables differ from request");
  we_idle_a: assert property (!o_plane_wr |-> o_plane_we == 4'h0)
    else $error("plane enable outside a write");
  io_hold_a: assert property (!i_io.rd |=> $stable(o_io_rdata))
    else $error("io read data moved without a read");
  index_upper_a: assert property (i_io.rd && i_io.addr == 16'h03ce |=> o_io_rdata[7:4] == 4'h0)
    else $error("index upper bits not zero");
  config_steady_a: assert property (!i_io.wr |=> $stable(o_graphics_select) && $stable(o_win_base))
    else $error("configuration changed without a host write");
endmodule
bind pgd_datapath pgd_props pgd_props_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_io(i_io),
  .i_mem(i_mem), .o_io_rdata(o_io_rdata), .o_mem_rdata(o_mem_rdata), .o_mem_rvalid(o_mem_rvalid),
  .o_plane_we(o_plane_we), .o_plane_wr(o_plane_wr), .o_graphics_select(o_graphics_select),
  .o_win_base(o_win_base));
`default_nettype wire

// File: testbench/pgd_plane_model.sv
`timescale 1ns/1ns
`default_nettype none
module pgd_plane_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [3:0]  i_we,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_rdata
);
  logic [31:0] mem_reg;
  // outside a read the bus shows the inverse so stale data never passes as valid
  assign o_rdata = i_rd ? mem_reg : ~mem_reg;
  // only enabled planes take the write data
  always @(posedge i_ref_clk) begin
    for (int p = 0; p < 4; p++) begin
      if (i_wr && i_we[p]) mem_reg[8*p +: 8] <= i_wdata[8*p +: 8];
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_pgd_datapath.sv
`timescale 1ns/1ns
`default_nettype none
`include "pgd_map.svh"
module test_pgd_datapath;
  import pgd_pkg::*;
  typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [7:0] rd;} pgd_reg_row_type;
  typedef struct packed {logic [7:0] lop; logic [7:0] mode; logic [7:0] mask; logic [7:0] host;
    logic [31:0] wexp; logic [7:0] rexp;} pgd_mem_row_type;
  localparam logic [31:0] lat_word = 32'hcc33_f00f;
  localparam logic [19:0] wbase [4] = '{20'ha0000, 20'ha0000, 20'hb0000, 20'hb8000};
  localparam logic [19:0] wlast [4] = '{20'hbffff, 20'hbffff, 20'hb7fff, 20'hbffff};
  localparam pgd_reg_row_type regs [10] = '{'{0, 8'hff, 8'h0f}, '{1, 8'hff, 8'h0f},
    '{2, 8'hff, 8'h0f}, '{3, 8'h1f, 8'h1f}, '{4, 8'hff, 8'h03}, '{5, 8'hff, 8'h7b},
    '{6, 8'hff, 8'h0f}, '{7, 8'hff, 8'h0f}, '{8, 8'hff, 8'hff}, '{9, 8'hff, 8'h00}};
  localparam pgd_mem_row_type rows [5] = '{
    '{8'h00, 8'h00, 8'hff, 8'ha5, 32'ha5a5_00ff, 8'h33}, '{8'h19, 8'h00, 8'h0f, 8'ha5, 32'hce31_f000, 8'h33},
    '{8'h19, 8'h01, 8'h0f, 8'ha5, 32'hcc33_f00f, 8'h33}, '{8'h08, 8'h02, 8'h3c, 8'h0a, 32'hcc03_f003, 8'h33},
    '{8'h10, 8'h0b, 8'hf0, 8'h3c, 32'hcc33_f03f, 8'h0f}};
  logic        i_ref_clk;
  logic        i_nrst;
  pgd_io_type  i_io;
  pgd_mem_type i_mem;
  logic [31:0] plane_rdata, o_plane_wdata, streams;
  logic [7:0]  o_io_rdata, o_mem_rdata;
  logic [3:0]  o_plane_we;
  logic        o_plane_wr, o_mem_rvalid, gsel;
  logic [19:0] base, wlim;
  logic [1:0]  shf;
  int          n_fail = 0;
  int          samples_checked = 0;
  pgd_datapath pgd_datapath_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_io(i_io), .i_mem(i_mem),
    .i_plane_rdata(plane_rdata), .o_io_rdata(o_io_rdata), .o_mem_rdata(o_mem_rdata),
    .o_plane_wdata(o_plane_wdata), .o_plane_we(o_plane_we), .o_plane_wr(o_plane_wr),
    .o_mem_rvalid(o_mem_rvalid), .o_win_base(base), .o_win_limit(wlim), .o_graphics_select(gsel),
    .o_shift_format(shf), .o_packed_pixel_streams(streams));
  pgd_plane_model pgd_plane_model_i (.i_ref_clk(i_ref_clk), .i_rd(i_mem.rd), .i_wr(o_plane_wr),
    .i_we(o_plane_we), .i_wdata(o_plane_wdata), .o_rdata(plane_rdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one io or memory cycle: request on one edge, released after the next
  task automatic io_cyc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) i_io <= '{wr, !wr, a, d};
    @(posedge i_ref_clk) i_io <= '0;
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] idx, input logic [7:0] d);
    io_cyc(1'b1, `PGD_PORT_INDEX, {4'h0, idx});
    io_cyc(1'b1, `PGD_PORT_DATA, d);
  endtask
  task automatic mem_cyc(input logic rd, input logic wr, input logic [7:0] d);
    @(posedge i_ref_clk) i_mem <= '{wr, rd, i_mem.addr_lo, i_mem.chain4, i_mem.plane_we, d};
    @(posedge i_ref_clk) i_mem <= '{1'b0, 1'b0, i_mem.addr_lo, i_mem.chain4, i_mem.plane_we, d};
    #1;
  endtask
  task automatic results;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // clock and hang guard
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #400000;
    n_fail++;
    results();
  end
  // main sequence
  initial begin
    i_nrst = 1'b0;
    i_io = '0;
    i_mem = '{1'b0, 1'b0, 2'h0, 1'b0, 4'hf, 8'h00};
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    foreach (regs[k]) begin
      reg_wr(regs[k].idx, regs[k].wd);
      io_cyc(1'b0, `PGD_PORT_DATA, 8'h00);
      chk(o_io_rdata, regs[k].rd);
    end
    $display("register rows done");
    io_cyc(1'b0, `PGD_PORT_INDEX, 8'h00);
    chk(o_io_rdata, 8'h09);
    chk(shf, 2'h3);
    for (int m = 0; m < 4; m++) begin
      reg_wr(4'h6, {4'h0, 2'(m), 2'b01});
      chk(base, wbase[m]);
      chk(wlim, wlast[m]);
      chk(gsel, 1'b1);
    end
    reg_wr(4'h0, 8'h05);
    reg_wr(4'h1, 8'h03);
    reg_wr(4'h2, 8'h05);
    reg_wr(4'h4, 8'h02);
    reg_wr(4'h7, 8'h0c);
    foreach (rows[k]) begin
      reg_wr(4'h3, rows[k].lop);
      reg_wr(4'h5, rows[k].mode);
      reg_wr(4'h8, rows[k].mask);
      pgd_plane_model_i.mem_reg = lat_word;
      mem_cyc(1'b1, 1'b0, 8'h00);
      chk(o_mem_rdata, rows[k].rexp);
      mem_cyc(1'b0, 1'b1, rows[k].host);
      chk(o_plane_wdata, rows[k].wexp);
      $display("memory row %0d done", k);
    end
    reg_wr(4'h5, 8'h20);
    chk(streams, 32'h5a5a_3c3c);
    // chained read, then a write lost to a read, then a gated write
    i_mem.chain4 <= 1'b1;
    i_mem.addr_lo <= 2'h1;
    mem_cyc(1'b1, 1'b0, 8'h00);
    chk(o_mem_rdata, 8'hf0);
    i_mem.plane_we <= 4'h5;
    mem_cyc(1'b1, 1'b1, 8'hff);
    chk(o_plane_wr, 1'b0);
    mem_cyc(1'b0, 1'b1, 8'hff);
    chk(o_plane_we, 4'h5);
    $display("awkward cases done");
    i_nrst <= 1'b0;
    #20;
    chk(base, 20'ha0000);
    chk(wlim, 20'hbffff);
    i_nrst <= 1'b1;
    results();
  end
endmodule
`default_nettype wire
